// ==== include/vdsp_pkg.sv ====
package vdsp_pkg;
    // register that carries the active-video blanking toggle bit
    localparam logic [7:0]  ACT_VID_CROP_REG_ADDR = 8'h12;
    localparam int          ACT_VID_VBI_TOG_BIT   = 2;
    // two-wire bus addresses picked by the address-select strap
    localparam logic [7:0]  BUS_ADDR_HIGH      = 8'hBA;
    localparam logic [7:0]  BUS_ADDR_LOW       = 8'hB8;
    // colour pll serial word
    localparam int          PLL_WORD_W         = 22;
    localparam int          PLL_CNT_W          = 5;
    localparam logic [4:0]  PLL_LAST_BIT       = 5'h16 - 5'h01;
    localparam logic [1:0]  RTC_DIV_LAST       = 2'h3;   // sclk/4 in rtc mode
    // line counter for the vertical-blank window
    localparam int          LINE_W             = 10;
    localparam logic [9:0]  VBLANK_START_RST   = 10'h000;
    localparam logic [9:0]  VBLANK_END_RST     = 10'h014;
    // strap capture cycles after system reset
    localparam logic [1:0]  STRAP_CAP_RST      = 2'h3;

    // multi-function pin use
    typedef enum logic [1:0] {
        VDSP_MF_IRQ  = 2'b00,
        VDSP_MF_GPO  = 2'b01,
        VDSP_MF_VBLANK = 2'b10
    } vdsp_mf_t;
    localparam vdsp_mf_t    MF_MODE_RST        = VDSP_MF_IRQ;
endpackage

// ==== core/vdsp_pins.sv ====
// Contract
// - active video high only during line active
// - blanking toggle selected by crop bit two
// - field pin: odd field flag or vlock
// - field pin alternate: chroma pll serial stream
// - serial bit per clock, rtc at quarter
// - multi-function pin can be interrupt request
// - general-purpose mode: pin equals host value
// - vblank mode: programmable start/end line window
// - power-down low halts processing, standby
// - standby keeps all configuration registers
// - reset pin restores defaults, restarts logic (ignored here while power-down is active)
// - bus lines open-drain, pull low only
// - address strap sampled at reset: BAh/B8h
// - pal line flag: 1 noninverted, 0 inverted
`timescale 1ns/100ps
module vdsp_pins
    import vdsp_pkg::*;
(
    input  wire logic                  sys_clk_i,        // 40 mhz sample clock
    input  wire logic                  rst_i,            // sync reset, active high
    input  wire logic                  power_down_n_i,   // pin, active low
    input  wire logic                  reset_n_i,        // pin, active low
    input  wire logic                  bus_address_select_i, // strap pin
    input  wire logic                  scl_i,            // bus clock wire level
    input  wire logic                  sda_i,            // bus data wire level
    input  wire logic                  scl_pull_i,       // engine holds clock low
    input  wire logic                  sda_pull_i,       // engine pulls data low
    input  wire logic                  h_active_i,       // line active time
    input  wire logic                  vblank_i,         // vertical blanking
    input  wire logic                  odd_field_i,      // current field is odd
    input  wire logic                  vlock_i,          // vertical lock
    input  wire logic                  frame_start_i,    // first line pulse
    input  wire logic                  line_start_i,     // new line pulse
    input  wire logic                  vsync_i,          // vertical sync
    input  wire logic                  line_inverted_i,  // pal phase inverted line
    input  wire logic                  irq_pending_i,    // pending host event
    input  wire logic [PLL_WORD_W-1:0] pll_word_i,       // colour pll state word
    input  wire logic                  cfg_wr_i,         // host config write strobe
    input  wire logic                  cfg_act_vid_vbi_i, // video flag runs in blanking
    input  wire logic                  cfg_field_serial_i, // field pin carries pll
    input  wire logic                  cfg_field_vlock_i,  // field pin shows vlock
    input  wire logic                  cfg_rtc_mode_i,   // rtc serial rate
    input  wire logic [1:0]            cfg_mf_mode_i,    // multi-function use
    input  wire logic                  cfg_gpo_i,        // general-purpose level
    input  wire logic [LINE_W-1:0]     cfg_vblank_start_i, // vblank first line
    input  wire logic [LINE_W-1:0]     cfg_vblank_end_i, // vblank line after last
    input  wire logic                  cfg_pal_line_i,   // vsync pin shows pal flag
    output logic                       active_video_flag_o, // active video
    output logic                       field_flag_o,     // field / serial pin
    output logic                       mf_pin_o,         // irq/gpo/vblank pin
    output logic                       vsync_pin_o,      // vsync / pal flag pin
    output logic                       scl_o,            // always low
    output logic                       scl_oe_o,         // pull clock low
    output logic                       sda_o,            // always low
    output logic                       sda_oe_o,         // pull data low
    output logic                       scl_sync_o,       // synced clock level
    output logic                       sda_sync_o,       // synced data level
    output logic [7:0]                 bus_address_o,    // selected bus address
    output logic                       standby_o         // in power-down standby
);

    // whole block state
    typedef struct packed {
        logic                  pd_m;         // sync first and second stages
        logic                  pd_s;
        logic                  rn_m;
        logic                  rn_s;
        logic                  sel_m;
        logic                  sel_s;
        logic                  scl_m;
        logic                  scl_s;
        logic                  sda_m;
        logic                  sda_s;
        logic                  act_vid_vbi;  // configuration
        logic                  field_serial;
        logic                  field_vlock;
        logic                  rtc_mode;
        vdsp_mf_t              mf_mode;
        logic                  gpo;
        logic [LINE_W-1:0]     vblank_start;
        logic [LINE_W-1:0]     vblank_end;
        logic                  pal_line;
        logic                  addr_sel;     // captured strap
        logic [1:0]            cap_cnt;
        logic                  act_vid;      // pin registers
        logic                  field;
        logic                  mf;
        logic                  vsync;
        logic [LINE_W-1:0]     line_cnt;
        logic [PLL_WORD_W-1:0] shift;        // pll serialiser
        logic [PLL_CNT_W-1:0]  bit_cnt;
        logic [1:0]            div_cnt;
    } vdsp_state_t;

    vdsp_state_t st;          // registered state
    vdsp_state_t next_st;     // next state
    vdsp_state_t rst_st;      // reset image
    logic        standby;     // power-down active
    logic        pin_rst;     // honoured reset pin
    logic        ser_tick;    // serialiser advance

    // reset image, all constants
    always_comb begin
        rst_st          = '0;
        rst_st.pd_m     = 1'b1;
        rst_st.pd_s     = 1'b1;
        rst_st.rn_m     = 1'b1;
        rst_st.rn_s     = 1'b1;
        rst_st.scl_m    = 1'b1;
        rst_st.scl_s    = 1'b1;
        rst_st.sda_m    = 1'b1;
        rst_st.sda_s    = 1'b1;
        rst_st.mf_mode  = MF_MODE_RST;
        rst_st.vblank_start = VBLANK_START_RST;
        rst_st.vblank_end = VBLANK_END_RST;
        rst_st.cap_cnt  = STRAP_CAP_RST;
    end

    assign standby  = !st.pd_s;
    // reset during power-down is not supported, so it is ignored there
    assign pin_rst  = !st.rn_s && st.pd_s;
    assign ser_tick = !st.rtc_mode || (st.div_cnt == RTC_DIV_LAST);

    // next-state logic
    always_comb begin
        next_st       = st;
        // pin synchronisers, first stage feeds only the second
        next_st.pd_m  = power_down_n_i;
        next_st.pd_s  = st.pd_m;
        next_st.rn_m  = reset_n_i;
        next_st.rn_s  = st.rn_m;
        next_st.sel_m = bus_address_select_i;
        next_st.sel_s = st.sel_m;
        next_st.scl_m = scl_i;
        next_st.scl_s = st.scl_m;
        next_st.sda_m = sda_i;
        next_st.sda_s = st.sda_m;

        if (pin_rst) begin
            // back to defaults; syncs keep running
            next_st.act_vid_vbi  = rst_st.act_vid_vbi;
            next_st.field_serial = rst_st.field_serial;
            next_st.field_vlock  = rst_st.field_vlock;
            next_st.rtc_mode     = rst_st.rtc_mode;
            next_st.mf_mode      = rst_st.mf_mode;
            next_st.gpo          = rst_st.gpo;
            next_st.vblank_start = rst_st.vblank_start;
            next_st.vblank_end   = rst_st.vblank_end;
            next_st.pal_line     = rst_st.pal_line;
            next_st.act_vid      = 1'b0;
            next_st.field        = 1'b0;
            next_st.mf           = 1'b0;
            next_st.vsync        = 1'b0;
            next_st.line_cnt     = '0;
            next_st.shift        = '0;
            next_st.bit_cnt      = '0;
            next_st.div_cnt      = '0;
            next_st.addr_sel     = st.sel_s;
            next_st.cap_cnt      = STRAP_CAP_RST;
        end else if (standby) begin
            // frozen: config kept, writes dropped, pins parked low
            next_st.act_vid = 1'b0;
            next_st.field = 1'b0;
            next_st.mf    = 1'b0;
            next_st.vsync = 1'b0;
        end else begin
            // strap still settling through the syncs after system reset
            if (st.cap_cnt != 2'h0) begin
                next_st.addr_sel = st.sel_s;
                next_st.cap_cnt  = st.cap_cnt - 2'h1;
            end
            // host configuration writes
            if (cfg_wr_i) begin
                next_st.act_vid_vbi  = cfg_act_vid_vbi_i;
                next_st.field_serial = cfg_field_serial_i;
                next_st.field_vlock  = cfg_field_vlock_i;
                next_st.rtc_mode     = cfg_rtc_mode_i;
                next_st.mf_mode      = vdsp_mf_t'(cfg_mf_mode_i);
                next_st.gpo          = cfg_gpo_i;
                next_st.vblank_start = cfg_vblank_start_i;
                next_st.vblank_end   = cfg_vblank_end_i;
                next_st.pal_line     = cfg_pal_line_i;
            end
            // active video, optionally silenced in blanking
            next_st.act_vid = h_active_i && (!vblank_i || st.act_vid_vbi);
            // line counter for the vblank window
            if (frame_start_i) begin
                next_st.line_cnt = '0;
            end else if (line_start_i) begin
                next_st.line_cnt = st.line_cnt + 10'h001;
            end
            // pll serialiser, divider only runs in rtc mode
            next_st.div_cnt = st.rtc_mode ? st.div_cnt + 2'h1 : 2'h0;
            if (ser_tick) begin
                if (st.bit_cnt == '0) begin
                    next_st.shift   = pll_word_i;
                    next_st.bit_cnt = PLL_LAST_BIT;
                end else begin
                    next_st.shift   = {st.shift[PLL_WORD_W-2:0], 1'b0};
                    next_st.bit_cnt = st.bit_cnt - 5'h01;
                end
            end
            // field pin: one function at a time
            if (st.field_serial) begin
                next_st.field = next_st.shift[PLL_WORD_W-1];
            end else begin
                next_st.field = st.field_vlock ? vlock_i : odd_field_i;
            end
            // multi-function pin mux
            case (st.mf_mode)
                VDSP_MF_IRQ:  next_st.mf = irq_pending_i;
                VDSP_MF_GPO:  next_st.mf = st.gpo;
                VDSP_MF_VBLANK: next_st.mf = (st.line_cnt >= st.vblank_start) &&
                                             (st.line_cnt <  st.vblank_end);
                default:      next_st.mf = 1'b0;
            endcase
            // vsync pin or pal line flag
            next_st.vsync = st.pal_line ? !line_inverted_i : vsync_i;
        end
    end

    // state register
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            st <= rst_st;
        end else begin
            st <= next_st;
        end
    end

    // outputs
    assign active_video_flag_o = st.act_vid;
    assign field_flag_o        = st.field;
    assign mf_pin_o            = st.mf;
    assign vsync_pin_o         = st.vsync;
    // open drain: drive low or release, never high
    assign scl_o               = 1'b0;
    assign sda_o               = 1'b0;
    assign scl_oe_o            = scl_pull_i;
    assign sda_oe_o            = sda_pull_i;
    assign scl_sync_o          = st.scl_s;
    assign sda_sync_o          = st.sda_s;
    assign bus_address_o       = st.addr_sel ? BUS_ADDR_HIGH : BUS_ADDR_LOW;
    assign standby_o           = standby;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    chk_vid_in_line: assert property (
        (h_active_i && !vblank_i && !standby && !pin_rst) |=> st.act_vid)
        else $error("active video low inside line");
    chk_vid_off_line: assert property (!h_active_i |=> !st.act_vid)
        else $error("active video high outside line");
    chk_vid_blank_sel: assert property (
        (vblank_i && !st.act_vid_vbi) |=> !st.act_vid)
        else $error("active video toggled in blanking");
    chk_field_odd_flag: assert property (
        (!st.field_serial && !st.field_vlock && !standby && !pin_rst)
        |=> st.field == $past(odd_field_i))
        else $error("field flag not odd field");
    chk_pll_genlock_shift: assert property (
        (!st.rtc_mode && st.bit_cnt != '0 && !standby && !pin_rst)
        |=> st.shift == {$past(st.shift[PLL_WORD_W-2:0]), 1'b0})
        else $error("genlock stream not one bit per clock");
    chk_pll_rtc_hold: assert property (
        (st.rtc_mode && st.div_cnt != RTC_DIV_LAST && !pin_rst) |=> $stable(st.shift))
        else $error("rtc stream faster than quarter rate");
    chk_gpo_level: assert property (
        (st.mf_mode == VDSP_MF_GPO && !standby && !pin_rst) |=> st.mf == $past(st.gpo))
        else $error("gpo pin differs from host value");
    chk_irq_follow: assert property (
        (st.mf_mode == VDSP_MF_IRQ && !standby && !pin_rst)
        |=> st.mf == $past(irq_pending_i))
        else $error("irq pin not following events");
    chk_vblank_window: assert property (
        (st.mf_mode == VDSP_MF_VBLANK && !standby && !pin_rst)
        |=> st.mf == ($past(st.line_cnt) >= $past(st.vblank_start) &&
                      $past(st.line_cnt) <  $past(st.vblank_end)))
        else $error("vblank pin outside programmed window");
    chk_standby_retain: assert property (
        standby |=> $stable(st.mf_mode) && $stable(st.gpo) && $stable(st.vblank_end))
        else $error("config lost in standby");
    chk_pin_reset_dflt: assert property (
        pin_rst |=> st.mf_mode == MF_MODE_RST && st.vblank_end == VBLANK_END_RST &&
                    !st.act_vid)
        else $error("reset pin did not restore defaults");
    chk_pal_flag: assert property (
        (st.pal_line && !standby && !pin_rst) |=> st.vsync == !$past(line_inverted_i))
        else $error("pal line flag wrong polarity");
endmodule

// ==== tb/vdsp_bus_model.sv ====
`timescale 1ns/100ps
// far side of the two-wire bus: pull-up resistors and a host that may pull low
module vdsp_bus_model (
    input  wire logic dev_scl_oe_i,    // device pulls clock low
    input  wire logic dev_sda_oe_i,    // device pulls data low
    input  wire logic host_scl_pull_i, // host pulls clock low
    input  wire logic host_sda_pull_i, // host pulls data low
    output logic      scl_o,           // resolved clock wire
    output logic      sda_o            // resolved data wire
);
    // a released line floats up to the pull-up, nobody ever drives high
    assign scl_o = ~(dev_scl_oe_i | host_scl_pull_i);
    assign sda_o = ~(dev_sda_oe_i | host_sda_pull_i);
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
module tb_top
    import vdsp_pkg::*;
;
    // expected pin levels for one cycle, field only checked when not serial
    typedef struct packed {logic act; logic fld; logic fchk; logic mf; logic vs;} vdsp_exp_t;
    logic sys_clk_i = 0, rst_i = 1, pwr_n = 1, rst_n = 1, strap = 1;
    logic fs = 1'b0, ls = 1'b0;  // frame and line start pulses
    logic [PLL_WORD_W-1:0] pll_w = 22'h2A_AAAA;  // colour pll word offered
    logic h_act = 0, vbl = 0, odd = 0, vlk = 0, vsy = 0, linv = 0, irq = 0;
    logic scl_pull = 0, sda_pull = 0, h_scl = 0, h_sda = 0, scl_w, sda_w;
    logic cfg_wr = 0, c_vbi = 0, c_ser = 0, c_vl = 0, c_rtc = 0, c_gpo = 0, c_pal = 0;
    logic [1:0] c_mode = 2'h0;
    logic [9:0] c_st = 10'h000, c_en = 10'h000;
    logic m_vbi = 0, m_ser = 0, m_vl = 0, m_gpo = 0, m_pal = 0; // model config
    logic [9:0] m_st = 10'h000, m_en = 10'h000, m_line = 10'h000; // model vblank window
    logic [1:0] m_mode = 2'h0;
    logic act_o, fld_o, mf_o, vs_o, scl_o, scl_oe, sda_o, sda_oe, scl_s, sda_s, stby;
    logic [7:0] addr_o;
    vdsp_exp_t q[$];     // notes from the driver, oldest first
    vdsp_exp_t e;        // note under comparison
    int seed = 2, error_cnt = 0, total_checks = 0, cyc = 0;
    always #12.5 sys_clk_i = ~sys_clk_i;  // 40 mhz
    vdsp_pins dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .power_down_n_i(pwr_n),
        .reset_n_i(rst_n), .bus_address_select_i(strap), .scl_i(scl_w), .sda_i(sda_w),
        .scl_pull_i(scl_pull), .sda_pull_i(sda_pull), .h_active_i(h_act), .vblank_i(vbl),
        .odd_field_i(odd), .vlock_i(vlk), .frame_start_i(fs), .line_start_i(ls),
        .vsync_i(vsy), .line_inverted_i(linv), .irq_pending_i(irq),
        .pll_word_i(pll_w), .cfg_wr_i(cfg_wr), .cfg_act_vid_vbi_i(c_vbi),
        .cfg_field_serial_i(c_ser), .cfg_field_vlock_i(c_vl), .cfg_rtc_mode_i(c_rtc),
        .cfg_mf_mode_i(c_mode), .cfg_gpo_i(c_gpo), .cfg_vblank_start_i(c_st),
        .cfg_vblank_end_i(c_en), .cfg_pal_line_i(c_pal), .active_video_flag_o(act_o),
        .field_flag_o(fld_o), .mf_pin_o(mf_o), .vsync_pin_o(vs_o), .scl_o(scl_o),
        .scl_oe_o(scl_oe), .sda_o(sda_o), .sda_oe_o(sda_oe), .scl_sync_o(scl_s),
        .sda_sync_o(sda_s), .bus_address_o(addr_o), .standby_o(stby));
    vdsp_bus_model bus (.dev_scl_oe_i(scl_oe), .dev_sda_oe_i(sda_oe),
        .host_scl_pull_i(h_scl), .host_sda_pull_i(h_sda), .scl_o(scl_w), .sda_o(sda_w));
    // one compare, counted, reported at once on a miss
    task automatic chk(input logic got, input logic exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %b exp %b", $time, msg, got, exp);
        end
    endtask
    // random video levels, one note per cycle of what the pins must show next
    task automatic step(input int n);
        vdsp_exp_t x;
        logic [31:0] r;
        repeat (n) begin
            @(posedge sys_clk_i);
            #2;
            r = $random(seed);
            {h_act, vbl, odd, vlk, vsy, linv, irq, ls} = r[7:0];
            fs = (r[10:8] == 3'h0);  // roughly one frame start in eight cycles
            x.act  = h_act & (m_vbi | ~vbl);
            x.fchk = ~m_ser;
            x.fld  = m_vl ? vlk : odd;
            x.mf   = (m_mode == 2'h0) ? irq : (m_mode == 2'h1) ? m_gpo :
                     (m_mode == 2'h2) ? (m_line >= m_st && m_line < m_en) : 1'b0;
            x.vs   = m_pal ? ~linv : vsy;
            q.push_back(x);
            // the line counter takes these pulses at the next edge
            if (fs) m_line = 10'h000;
            else if (ls) m_line = m_line + 10'h001;
        end
        // pulses must not linger into the next phase
        @(posedge sys_clk_i);
        #2;
        {fs, ls} = 2'b00;
    endtask
    // host config write; the model follows once the write has landed
    task automatic cfg(input logic [1:0] md, input logic g, vb, sr, vl, rt, pl,
                       input logic [9:0] st, en);
        @(posedge sys_clk_i);
        #2;
        {c_mode, c_gpo, c_vbi, c_ser, c_vl, c_rtc, c_pal, c_st, c_en} =
            {md, g, vb, sr, vl, rt, pl, st, en};
        cfg_wr = 1;
        @(posedge sys_clk_i);
        #2;
        cfg_wr = 0;
        @(posedge sys_clk_i);
        {m_mode, m_gpo, m_vbi, m_ser, m_vl, m_pal} = {md, g, vb, sr, vl, pl};
        m_st = st;
        m_en = en;
    endtask
    // counts field pin changes over 40 cycles of the offered pll word
    task automatic ser_runs(input int lo, input int hi);
        int t;
        logic p;
        t = 0;
        @(posedge sys_clk_i);
        #1;
        p = fld_o;
        repeat (40) begin
            @(posedge sys_clk_i);
            #1;
            if (fld_o !== p) t++;
            p = fld_o;
        end
        total_checks++;
        if (t < lo || t > hi) begin
            error_cnt++;
            $display("wrong value at %0t: serial toggles %0d", $time, t);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // watcher: outputs settle 1 ns after the edge, oldest note first
    always @(posedge sys_clk_i) begin
        #1;
        if (q.size() > 0) begin
            e = q.pop_front();
            chk(act_o, e.act, "active video");
            if (e.fchk) chk(fld_o, e.fld, "field flag");
            chk(mf_o, e.mf, "mf pin");
            chk(vs_o, e.vs, "vsync pin");
        end
    end
    // hang guard, far beyond the roughly 540 cycles the run needs
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            $display("wrong value at %0t: run timed out", $time);
            final_report();
        end
    end
    initial begin
        repeat (20) @(posedge sys_clk_i);
        #2;
        rst_i = 0;
        repeat (6) @(posedge sys_clk_i);
        #1;
        chk(addr_o === BUS_ADDR_HIGH, 1'b1, "strap high address");
        step(20);
        for (int i = 0; i < 8; i++) begin
            cfg(2'(i), i[2], i[0], 1'b0, i[1], 1'b0, i[2], i[2] ? 10'h002 : 10'h000,
                i[2] ? 10'h006 : 10'h003);
            step(25);
        end
        repeat (2) @(posedge sys_clk_i);
        cfg(2'h0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 10'h000, 10'h000);
        ser_runs(39, 40);
        cfg(2'h0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 10'h000, 10'h000);
        ser_runs(9, 10);
        #1;
        pll_w = 22'h3F_F800;  // new word must reach the pin after the next reload
        cfg(2'h0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 10'h000, 10'h000);
        repeat (23) @(posedge sys_clk_i);
        ser_runs(3, 4);
        cfg(2'h1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 10'h000, 10'h000);
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk_i);
            #2;
            {scl_pull, sda_pull, h_scl, h_sda} = 4'($random(seed));
            #1;
            chk(scl_oe === scl_pull && sda_oe === sda_pull, 1'b1, "pull enable");
            chk(scl_o === 1'b0 && sda_o === 1'b0, 1'b1, "drive level");
            repeat (4) @(posedge sys_clk_i);
            #1;
            chk(scl_s, ~(scl_pull | h_scl), "clock wire");
            chk(sda_s, ~(sda_pull | h_sda), "data wire");
        end
        @(posedge sys_clk_i);
        #2;
        pwr_n = 0;
        repeat (4) @(posedge sys_clk_i);
        #2;
        c_gpo = 0;       // write attempt while standing by must be dropped
        cfg_wr = 1;
        @(posedge sys_clk_i);
        #2;
        cfg_wr = 0;
        repeat (3) @(posedge sys_clk_i);
        #1;
        chk(stby, 1'b1, "standby");
        chk(mf_o, 1'b0, "pin in standby");
        #1;
        pwr_n = 1;
        repeat (5) @(posedge sys_clk_i);
        #1;
        chk(stby, 1'b0, "resume");
        step(10);
        repeat (2) @(posedge sys_clk_i);
        #2;
        strap = 0;
        // pin reset only while powered up, as the pin allows
        rst_n = 0;
        repeat (5) @(posedge sys_clk_i);
        #2;
        rst_n = 1;
        repeat (6) @(posedge sys_clk_i);
        #1;
        chk(addr_o === BUS_ADDR_LOW, 1'b1, "strap low address");
        {m_mode, m_gpo, m_vbi, m_ser, m_vl, m_pal} = '0;
        m_line = 10'h000;
        m_st = VBLANK_START_RST;
        m_en = VBLANK_END_RST;
        step(20);
        repeat (2) @(posedge sys_clk_i);
        final_report();
    end
endmodule
